//--- hdl/bpp_defs.vh
`ifndef BPP_DEFS_VH
`define BPP_DEFS_VH

// Command opcodes.
`define BPP_OP_PROG_B1 8'h02
`define BPP_OP_RMW_B1 8'h58
`define BPP_OP_RMW_B2 8'h59

// Address layout: 14-bit page number over an 8-bit byte column, 23-bit logical address.
`define BPP_ADDR_BITS 23
`define BPP_ADDR_BYTES 3
`define BPP_COL_BITS 8
`define BPP_PAGE_LSB 8
`define BPP_PAGE_MSB 21

// Erased array state is all ones.
`define BPP_ERASED_BYTE 8'hff

// Array timing in nanoseconds, converted to mclk cycles in the main module.
`define BPP_CLK_PERIOD_NS 20
`define BPP_PER_BYTE_PROGRAM_TIME_NS 8000
`define BPP_MAX_PROGRAM_TIME_NS 4000000
`define BPP_PAGE_ERASE_TIME_NS 100000

`endif

//--- hdl/bpp_mem.v
`timescale 1ns/1ps
`default_nettype none

// Simple synchronous memory with registered read data.
module bpp_mem #(
  parameter AW = 8,
  parameter DW = 8
) (
  // Clock.
  input wire clk,
  // Write port.
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [DW-1:0] wrData,
  // Read port.
  input wire [AW-1:0] rdAddr,
  output reg [DW-1:0] rdData
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // One write and one registered read per clock.
  always @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule // bpp_mem

`default_nettype wire

//--- hdl/bpp_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "bpp_defs.vh"

// Overview of operation
// R1: Opcode 02h loads buffer 1 then programs up to a page into erased cells.
// R2: After address bytes, data bytes fill buffer 1, wrapping at the buffer end.
// R3: Page bits and byte column form a 23-bit logical address A22 to A0; the page is taken from A21 to A8 and A22 is not decoded.
// R4: For 02h, programming starts when chip select rises after the data.
// R5: For 02h, only bytes that received data are programmed; others keep content.
// R6: Chip select must rise on a byte boundary, else the command is dropped.
// R7: 02h program time is byte count times per-byte time, capped at maximum.
// R8: Opcode 58h uses buffer 1, 59h buffer 2; one to a page of data bytes.
// R9: Read-modify-write data wraps the buffer position at the buffer end.
// R10: Read-modify-write copies page, merges bytes, erases and reprograms the page.
// R11: Read-modify-write with no data bytes performs an automatic page rewrite.
// R12: Read-modify-write reprogramming is self-timed within the maximum program time.
// R13: Any page erase leaves every bit at logic one before programming.
// R14: Device shows busy during self-timed work and ignores new program commands.
module bpp_sequencer #(
  parameter PAGE_BITS = 14,
  parameter COL_BITS = `BPP_COL_BITS,
  parameter [31:0] BYTE_CYC = (`BPP_PER_BYTE_PROGRAM_TIME_NS + `BPP_CLK_PERIOD_NS - 1) / `BPP_CLK_PERIOD_NS,
  parameter [31:0] MAX_CYC = `BPP_MAX_PROGRAM_TIME_NS / `BPP_CLK_PERIOD_NS,
  parameter [31:0] ERASE_CYC = (`BPP_PAGE_ERASE_TIME_NS + `BPP_CLK_PERIOD_NS - 1) / `BPP_CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire mclk,
  input wire sys_rst,
  // Serial link pins, asynchronous to mclk.
  input wire sclk,
  input wire csN,
  input wire sdi,
  // Status toward the host.
  output reg busy_reg,
  output reg abortFlag_reg,
  output reg [`BPP_ADDR_BITS-1:0] lastAddr_reg
);

  localparam ST_IDLE = 3'd0;
  localparam ST_READ = 3'd1;
  localparam ST_ERASE = 3'd2;
  localparam ST_PROG = 3'd3;
  localparam ST_WAIT = 3'd4;
  localparam NBYTE = 1 << COL_BITS;

  // Two-stage synchronisers; logic reads the second stage, and sclk adds a third stage for edge detection.
  reg [2:0] sclkSync_reg;
  reg [1:0] csSync_reg;
  reg [1:0] sdiSync_reg;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sclkSync_reg <= 3'h7;
      csSync_reg <= 2'h3;
      sdiSync_reg <= 2'h0;
    end else begin
      sclkSync_reg <= {sclkSync_reg[1:0], sclk};
      csSync_reg <= {csSync_reg[0], csN};
      sdiSync_reg <= {sdiSync_reg[0], sdi};
    end
  end
  reg csPrev_reg;
  wire csLow = ~csSync_reg[1];
  wire sclkRise = sclkSync_reg[1] & ~sclkSync_reg[2];
  wire csRise = csSync_reg[1] & ~csPrev_reg;

  // Clamp a cycle product to the maximum program time.
  function [31:0] progCycles;
    input [31:0] n;
    reg [31:0] p;
    begin
      p = n * BYTE_CYC;
      progCycles = (p > MAX_CYC) ? MAX_CYC : p;
    end
  endfunction

  // Frame shift state.
  reg [2:0] bitCnt_reg;
  reg [7:0] shift_reg;
  reg [2:0] byteIdx_reg;
  reg [7:0] opcode_reg;
  reg [`BPP_ADDR_BITS-1:0] addr_reg;
  reg [COL_BITS-1:0] col_reg;
  reg [COL_BITS:0] dataCnt_reg;
  reg [NBYTE-1:0] touched_reg;
  reg cmdOk_reg;
  wire [7:0] rxByte = {shift_reg[6:0], sdiSync_reg[1]};
  wire byteDone = csLow & sclkRise & (bitCnt_reg == 3'd7);
  wire inData = (byteIdx_reg == 3'd4);
  wire isProg = (opcode_reg == `BPP_OP_PROG_B1); // R1
  wire isRmw = (opcode_reg == `BPP_OP_RMW_B1) | (opcode_reg == `BPP_OP_RMW_B2);
  wire useBuf2 = (opcode_reg == `BPP_OP_RMW_B2); // R8

  // Sequencer state.
  reg [2:0] state_reg;
  reg [COL_BITS:0] seqCol_reg;
  reg [31:0] timer_reg;
  reg seqBuf2_reg;
  reg seqRmw_reg;
  reg [PAGE_BITS-1:0] seqPage_reg;

  // Buffers, plus the main array modelled as one memory holding every page.
  wire bufWrLoad = byteDone & inData & cmdOk_reg & ~busy_reg;
  wire [COL_BITS-1:0] seqIdx = seqCol_reg[COL_BITS-1:0];
  wire [7:0] b1Q;
  wire [7:0] b2Q;
  wire [7:0] arrQ;
  wire [COL_BITS-1:0] copyIdx = seqIdx - 1'b1;
  wire copyWr = (state_reg == ST_READ) & (seqCol_reg != 0) & ~touched_reg[copyIdx];
  wire b1We = (bufWrLoad & ~useBuf2) | (copyWr & ~seqBuf2_reg);
  wire b2We = (bufWrLoad & useBuf2) | (copyWr & seqBuf2_reg);
  wire [COL_BITS-1:0] bufWa = bufWrLoad ? col_reg : copyIdx;
  wire [7:0] bufWd = bufWrLoad ? rxByte : arrQ;
  wire [7:0] bufQ = seqBuf2_reg ? b2Q : b1Q;
  wire progWr = (state_reg == ST_PROG) & (seqCol_reg != 0) & (seqRmw_reg | touched_reg[copyIdx]); // R5
  wire eraseWr = (state_reg == ST_ERASE) & ~seqCol_reg[COL_BITS];
  wire arrWe = progWr | eraseWr;
  // Program can only clear bits of the pre-erased cell; erase drives ones.
  wire [7:0] arrWd = eraseWr ? `BPP_ERASED_BYTE : (seqRmw_reg ? bufQ : (arrQ & bufQ)); // R13
  wire [COL_BITS-1:0] arrWa = eraseWr ? seqIdx : copyIdx;
  wire [PAGE_BITS+COL_BITS-1:0] arrAddrRd = {seqPage_reg, seqIdx};
  wire [PAGE_BITS+COL_BITS-1:0] arrAddrWr = {seqPage_reg, arrWa};

  bpp_mem #(.AW(COL_BITS), .DW(8)) uBuf1 (.clk(mclk), .wrEn(b1We), .wrAddr(bufWa), .wrData(bufWd),
    .rdAddr(seqIdx), .rdData(b1Q));
  bpp_mem #(.AW(COL_BITS), .DW(8)) uBuf2 (.clk(mclk), .wrEn(b2We), .wrAddr(bufWa), .wrData(bufWd),
    .rdAddr(seqIdx), .rdData(b2Q));
  bpp_mem #(.AW(PAGE_BITS + COL_BITS), .DW(8)) uArray (.clk(mclk), .wrEn(arrWe), .wrAddr(arrAddrWr),
    .wrData(arrWd), .rdAddr(arrAddrRd), .rdData(arrQ));

  // Serial receive: opcode, three address bytes, then data into the buffer.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      csPrev_reg <= 1'b1;
      bitCnt_reg <= 3'd0;
      shift_reg <= 8'h00;
      byteIdx_reg <= 3'd0;
      opcode_reg <= 8'h00;
      addr_reg <= {`BPP_ADDR_BITS{1'b0}};
      col_reg <= {COL_BITS{1'b0}};
      dataCnt_reg <= {(COL_BITS+1){1'b0}};
      touched_reg <= {NBYTE{1'b0}};
      cmdOk_reg <= 1'b0;
    end else begin
      csPrev_reg <= csSync_reg[1];
      if (!csLow) begin
        bitCnt_reg <= 3'd0;
        byteIdx_reg <= 3'd0;
      end else if (sclkRise) begin
        bitCnt_reg <= bitCnt_reg + 3'd1;
        shift_reg <= rxByte;
        if (bitCnt_reg == 3'd7) begin
          if (byteIdx_reg == 3'd0) begin
            opcode_reg <= rxByte;
            // A command arriving while busy is not accepted.
            cmdOk_reg <= ~busy_reg; // R14
            // A refused frame must not disturb the byte map that a running merge still reads.
            if (!busy_reg) begin
              touched_reg <= {NBYTE{1'b0}};
              dataCnt_reg <= {(COL_BITS+1){1'b0}};
            end
          end else if (!inData) begin
            addr_reg <= {addr_reg[`BPP_ADDR_BITS-9:0], rxByte}; // R3
            if (byteIdx_reg == 3'd3) begin
              col_reg <= rxByte[COL_BITS-1:0];
            end
          end else if (bufWrLoad) begin
            // Wrap from the last buffer byte back to the first.
            col_reg <= col_reg + 1'b1; // R2 R9
            touched_reg[col_reg] <= 1'b1;
            if (!dataCnt_reg[COL_BITS]) begin
              dataCnt_reg <= dataCnt_reg + 1'b1;
            end
          end
          if (!inData) begin
            byteIdx_reg <= byteIdx_reg + 3'd1;
          end
        end
      end
    end
  end

  // Self-timed sequencer launched by the rising chip select.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      seqCol_reg <= {(COL_BITS+1){1'b0}};
      timer_reg <= 32'h0;
      seqBuf2_reg <= 1'b0;
      seqRmw_reg <= 1'b0;
      seqPage_reg <= {PAGE_BITS{1'b0}};
      busy_reg <= 1'b0;
      abortFlag_reg <= 1'b0;
      lastAddr_reg <= {`BPP_ADDR_BITS{1'b0}};
    end else begin
      // The interval runs alongside the internal steps, so busy ends when the later of the two is done.
      if (busy_reg && timer_reg > 32'd1) begin
        timer_reg <= timer_reg - 32'd1; // R7 R12
      end
      case (state_reg)
        ST_IDLE: begin
          if (csRise && cmdOk_reg && byteIdx_reg == 3'd4 && (isProg || isRmw)) begin
            if (bitCnt_reg != 3'd0) begin
              abortFlag_reg <= 1'b1; // R6
            end else if (isProg && dataCnt_reg == 0) begin
              abortFlag_reg <= 1'b0;
            end else begin
              abortFlag_reg <= 1'b0;
              busy_reg <= 1'b1; // R14
              seqBuf2_reg <= useBuf2;
              seqRmw_reg <= isRmw;
              seqPage_reg <= addr_reg[`BPP_PAGE_MSB:`BPP_PAGE_LSB];
              // Report the address the host sent, not where the wrapping column pointer ended.
              lastAddr_reg <= addr_reg; // R3
              seqCol_reg <= {(COL_BITS+1){1'b0}};
              // No data bytes turns the merge into a plain page rewrite.
              state_reg <= isRmw ? ST_READ : ST_PROG; // R4 R10 R11
              timer_reg <= isRmw ? MAX_CYC : progCycles({23'h0, dataCnt_reg}); // R7 R12
            end
          end
        end
        ST_READ: begin
          seqCol_reg <= seqCol_reg + 1'b1;
          if (seqCol_reg == NBYTE) begin
            seqCol_reg <= {(COL_BITS+1){1'b0}};
            state_reg <= ST_ERASE;
          end
        end
        ST_ERASE: begin
          seqCol_reg <= seqCol_reg + 1'b1; // R13
          if (seqCol_reg == NBYTE) begin
            seqCol_reg <= {(COL_BITS+1){1'b0}};
            state_reg <= ST_PROG;
          end
        end
        ST_PROG: begin
          seqCol_reg <= seqCol_reg + 1'b1;
          if (seqCol_reg == NBYTE) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Busy holds until the self-timed interval elapses.
          if (timer_reg <= 32'd1) begin
            busy_reg <= 1'b0; // R14 R12
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // bpp_sequencer

`default_nettype wire

//--- sim/bpp_sequencer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Status checks on the sequencer pins.
module bpp_sequencer_assertions #(
  parameter int MAX_CYC = 2000
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Chip select pin.
  input wire logic csN,
  // Status.
  input wire logic busy_reg,
  input wire logic abortFlag_reg,
  input wire logic [22:0] lastAddr_reg
);
  logic [31:0] busyCnt_reg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Busy span length; a short span means a skipped internal step.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) busyCnt_reg <= 32'h0;
    else busyCnt_reg <= busy_reg ? busyCnt_reg + 32'h1 : 32'h0;
  end
  sequence launch; $rose(busy_reg); endsequence
  sequence dropped; $rose(abortFlag_reg); endsequence
  a_launch_cs_high: assert property (launch |-> csN) else $error("busy rose in a frame");
  a_busy_span_held: assert property (launch |=> busy_reg [*8]) else $error("busy too short");
  a_busy_min_len: assert property ($fell(busy_reg) |-> busyCnt_reg >= 32'd250) else $error("busy span short");
  a_busy_max_len: assert property (busy_reg |-> busyCnt_reg < MAX_CYC) else $error("busy span long");
  a_addr_busy_stable: assert property (busy_reg && $past(busy_reg) |-> $stable(lastAddr_reg)) else $error("addr moved");
  a_addr_at_launch: assert property ($changed(lastAddr_reg) |-> ##[0:8] busy_reg) else $error("addr without op");
  a_drop_cs_high: assert property (dropped |-> csN) else $error("abort in a frame");
  a_drop_no_launch: assert property (dropped |-> !busy_reg [*8]) else $error("aborted frame ran");
  a_launch_clears_drop: assert property (launch |-> ##[0:4] !abortFlag_reg) else $error("abort kept");
endmodule // bpp_sequencer_assertions

bind bpp_sequencer bpp_sequencer_assertions #(.MAX_CYC(MAX_CYC)) bpp_sequencer_assertions_i (.mclk(mclk),
  .sys_rst(sys_rst), .csN(csN), .busy_reg(busy_reg), .abortFlag_reg(abortFlag_reg),
  .lastAddr_reg(lastAddr_reg));
`default_nettype wire

//--- sim/bpp_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial link in mode 0.
module bpp_host (
  // Clock.
  input wire logic mclk,
  // Serial pins.
  output var logic sclk,
  output var logic csN,
  output var logic sdi
);
  // The serial clock stands low between frames.
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    sdi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Sends n bits msb first; sclk phases are 4 mclk, giving a 160 ns period.
  task automatic frame(input logic [63:0] v, input int n);
    tick(1);
    csN = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = v[63-i];
      tick(4);
      sclk = 1'b1;
      tick(4);
      sclk = 1'b0;
    end
    tick(4);
    csN = 1'b1;
    sdi = ~sdi; // Released line no longer shows the last bit.
    tick(6);
  endtask
endmodule // bpp_host
`default_nettype wire

//--- sim/buffered_partial_page_program_tb.sv
`timescale 1ns/1ps
`default_nettype none
module buffered_partial_page_program_tb;
  localparam int BYTE_CYC = 100;
  localparam int MAX_CYC = 2000;
  logic mclk = 1'b0;
  logic sysRst = 1'b1;
  wire sclk, csN, sdi, busy, abortFlag;
  wire [22:0] lastAddr;
  int err_total = 0;
  int check_count = 0;
  // Short timers keep the run brief.
  bpp_sequencer #(.BYTE_CYC(BYTE_CYC), .MAX_CYC(MAX_CYC)) bpp_sequencer_i (.mclk(mclk), .sys_rst(sysRst),
    .sclk(sclk), .csN(csN), .sdi(sdi), .busy_reg(busy), .abortFlag_reg(abortFlag), .lastAddr_reg(lastAddr));
  bpp_host bpp_host_i (.mclk(mclk), .sclk(sclk), .csN(csN), .sdi(sdi));
  initial forever #10 mclk = ~mclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_rise();
    int w;
    w = 0;
    while (busy !== 1'b1 && w < 50) begin
      bpp_host_i.tick(1);
      w++;
    end
    check(busy, 1'b1);
  endtask
  task automatic wait_fall(output int len);
    len = 0;
    while (busy === 1'b1 && len < 5000) begin
      bpp_host_i.tick(1);
      len++;
    end
  endtask
  // Cut three bits into a data byte: dropped, flagged, nothing runs.
  task automatic t_misaligned();
    bpp_host_i.frame({8'h02, 24'h012345, 8'ha5, 24'h0}, 43);
    bpp_host_i.tick(20);
    check(abortFlag, 1'b1);
    check(busy, 1'b0);
  endtask
  // Four bytes; the program time follows the byte count.
  task automatic t_prog();
    int len;
    bpp_host_i.frame({8'h02, 24'h012345, 32'h11223344}, 64);
    wait_rise();
    check(lastAddr, 23'h012345);
    check(abortFlag, 1'b0);
    wait_fall(len);
    check(len >= 4 * BYTE_CYC - 20 && len < 4 * BYTE_CYC + 300, 1'b1);
  endtask
  // Top page with no data bytes becomes a rewrite.
  task automatic t_rewrite();
    int len;
    bpp_host_i.frame({8'h59, 24'h3fff00, 32'h0}, 32);
    wait_rise();
    check(lastAddr, 23'h3fff00);
    wait_fall(len);
    check(len >= MAX_CYC - 20 && len < MAX_CYC + 300, 1'b1);
  endtask
  // Data wraps past the last column; a frame sent while busy is ignored.
  task automatic t_refuse();
    int len;
    bpp_host_i.frame({8'h58, 24'h0000ff, 16'ha1b2, 16'h0}, 48);
    wait_rise();
    check(lastAddr, 23'h0000ff);
    bpp_host_i.frame({8'h02, 24'h001000, 8'h5a, 24'h0}, 40);
    wait_fall(len);
    bpp_host_i.tick(30);
    check(busy, 1'b0);
    check(lastAddr, 23'h0000ff);
    check(bpp_sequencer_i.uArray.mem[22'h0000ff], 8'ha1);
    check(bpp_sequencer_i.uArray.mem[22'h000000], 8'hb2);
  endtask
  initial begin
    bpp_host_i.tick(16);
    sysRst = 1'b0;
    bpp_host_i.tick(4);
    check({busy, abortFlag, lastAddr}, 32'h0);
    t_misaligned();
    t_prog();
    t_rewrite();
    t_refuse();
    results();
  end
  // Watchdog well beyond the expected span of all scenarios.
  initial begin
    #1000000;
    err_total++;
    results();
  end
endmodule // buffered_partial_page_program_tb
`default_nettype wire
